/* File: logic/power_mode_map.vh */
// Constants for the low power mode controller.
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH
`define SLOW_DIV 32
`define SLOW_DIV_W 5
`define STAB_CYCLES 256
`define STAB_W 9
`define HALT_OPCODE 8'h8e
`define WFI_OPCODE 8'h8f
`define EXT_RESET_MIN_NS 42000
`define CLK_PERIOD_NS 20
`define EXT_RESET_MIN_CYCLES ((`EXT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: logic/slow_clock_divider.v */
// Divider that produces the reduced-speed clock enable.
`timescale 1ns/100ps
`default_nettype none
module slow_clock_divider #(
    parameter DIV = 32,
    parameter W = 5
) (
    input wire i_mclk,
    input wire i_nrst,
    input wire i_run,
    output reg o_tick
);
    reg [W-1:0] cnt_reg;
    always @(posedge i_mclk) begin
        if (!i_nrst) begin
            cnt_reg <= {W{1'b0}};
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_reg <= {W{1'b0}};
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt_reg == DIV[W-1:0] - 1'b1);
            if (cnt_reg == DIV[W-1:0] - 1'b1) begin
                cnt_reg <= {W{1'b0}};
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
endmodule // slow_clock_divider
`default_nettype wire

/* File: logic/low_power_mode_controller.v */
// Power mode controller: slow, wait, active halt and full halt sequencing.
// Contract
// [R1] Slow mode follows slow_select_bit of the main clock control register.
// [R2] In slow mode CPU and peripheral clock enables run at oscillator divided by 32.
// [R3] Wait while slow gives slow-wait, peripherals keep the divided clock.
// [R4] Wait instruction stops CPU clock, peripherals stay clocked.
// [R5] Entering wait clears the interrupt mask; other state is kept.
// [R6] Wait lasts until interrupt or reset, then vectors to the routine.
// [R7] Servicing pushes condition codes and sets mask; pop restores it.
// [R8] Halt picks timer-kept variant if timebase enable, or overflow enable with select 01.
// [R9] Timer-kept variant off when timebase off and select low 0, overflow off, or 11.
// [R10] Only lite timer, autoreload timer interrupts or reset leave timer-kept halt.
// [R11] Reset leaving timer-kept halt waits 256 CPU cycles before the vector fetch.
// [R12] Interrupt leaving timer-kept halt resumes at once, no delay.
// [R13] Entering timer-kept halt clears the mask; pending interrupt wakes at once.
// [R14] Timer-kept halt runs only oscillator and selected timer counter.
// [R15] Timer-kept halt with watchdog on and option clear gives no watchdog reset.
// [R16] Halt enters full halt whenever timer-kept variant is disabled; the code stays in run instead when watchdog and option bit are both set.
// [R17] Full halt wake restarts oscillator, then waits 256 cycles before CPU runs.
// [R18] Entering full halt forces the interrupt mask to zero.
// [R19] Full halt stops the oscillator and every peripheral on it.
// [R20] Halt with watchdog on may give watchdog reset per the option bit.
// [R21] External reset leaving full halt is held at least 42 us.
// [R22] Opcode 0x8e is decoded as halt and requests halt entry.
// [R23] After wake and delay, return to run keeping the slow setting.
// [R24] Delay is counted on the restarted oscillator; clock released at full count.
`timescale 1ns/100ps
`default_nettype none
`include "power_mode_map.vh"
module low_power_mode_controller #(
    parameter STAB_CYCLES = `STAB_CYCLES,
    parameter STAB_W = `STAB_W
) (
    input wire i_mclk,
    input wire i_nrst,
    input wire i_slow_select_bit,
    input wire i_instr_valid,
    input wire [7:0] i_opcode,
    input wire i_timebase_irq_enable,
    input wire i_overflow_irq_enable,
    input wire i_timer_clock_select_high,
    input wire i_timer_clock_select_low,
    input wire i_watchdog_enabled,
    input wire i_watchdog_halt_option,
    input wire i_irq_pending,
    input wire i_irq_halt_capable,
    input wire i_irq_timer_wake,
    input wire i_wake_reset,
    input wire i_irq_taken,
    input wire i_cc_pop,
    input wire i_cc_pop_mask,
    output reg o_cpu_clk_en,
    output reg o_periph_clk_en,
    output reg o_timer_clk_en,
    output reg o_osc_on,
    output reg o_mask_clear,
    output reg o_interrupt_mask,
    output reg o_cc_push,
    output reg o_irq_service,
    output reg o_reset_vector_fetch,
    output reg o_watchdog_reset,
    output reg o_slow_active,
    output reg [4:0] o_mode
);
    localparam [4:0] ST_RUN = 5'h01;
    localparam [4:0] ST_WAIT = 5'h02;
    localparam [4:0] ST_ACTHALT = 5'h04;
    localparam [4:0] ST_HALT = 5'h08;
    localparam [4:0] ST_STAB = 5'h10;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [STAB_W-1:0] stab_reg;
    reg [STAB_W-1:0] stab_next;
    reg stab_is_reset_reg;
    reg stab_is_reset_next;
    reg mask_reg;
    reg mask_next;
    reg slow_reg;
    wire slow_tick;
    wire fast_tick;
    wire tick;
    wire is_halt;
    wire is_wfi;
    wire act_halt_en;
    wire stab_done;

    // The divider only runs while slow is selected, so run-mode timing is undisturbed.
    slow_clock_divider #(
        .DIV(`SLOW_DIV),
        .W(`SLOW_DIV_W)
    ) u_div (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_run(slow_reg),
        .o_tick(slow_tick)
    );

    assign fast_tick = 1'b1;
    assign tick = slow_reg ? slow_tick : fast_tick; // [R2]
    assign is_halt = i_instr_valid && (i_opcode == `HALT_OPCODE); // [R22]
    assign is_wfi = i_instr_valid && (i_opcode == `WFI_OPCODE);
    // Table decode of the timer-kept halt enable. [R8] [R9]
    assign act_halt_en = i_timebase_irq_enable ||
        (i_overflow_irq_enable && !i_timer_clock_select_high && i_timer_clock_select_low);
    assign stab_done = (stab_reg == STAB_CYCLES[STAB_W-1:0] - 1'b1);

    always @(posedge i_mclk) begin
        if (!i_nrst) begin
            slow_reg <= 1'b0;
        end else begin
            slow_reg <= i_slow_select_bit; // [R1] [R23]
        end
    end

    always @* begin
        state_next = state_reg;
        stab_next = stab_reg;
        stab_is_reset_next = stab_is_reset_reg;
        mask_next = mask_reg;
        if (i_irq_taken) begin
            mask_next = 1'b1; // [R7]
        end else if (i_cc_pop) begin
            mask_next = i_cc_pop_mask; // [R7]
        end
        case (state_reg)
            ST_RUN: begin
                if (is_wfi) begin
                    state_next = ST_WAIT; // [R4] [R3]
                    mask_next = 1'b0; // [R5]
                end else if (is_halt) begin
                    mask_next = 1'b0; // [R13] [R18]
                    if (act_halt_en) begin
                        state_next = ST_ACTHALT; // [R8] [R15]
                    end else if (!(i_watchdog_enabled && i_watchdog_halt_option)) begin
                        state_next = ST_HALT; // [R16] [R20]
                    end
                end
            end
            ST_WAIT: begin
                if (i_irq_pending || i_wake_reset) begin
                    state_next = ST_RUN; // [R6] [R23]
                end
            end
            ST_ACTHALT: begin
                if (i_wake_reset) begin
                    state_next = ST_STAB; // [R11]
                    stab_next = {STAB_W{1'b0}};
                    stab_is_reset_next = 1'b1;
                end else if (i_irq_pending && i_irq_timer_wake) begin
                    state_next = ST_RUN; // [R10] [R12]
                end
            end
            ST_HALT: begin
                if (i_wake_reset || (i_irq_pending && i_irq_halt_capable)) begin
                    state_next = ST_STAB; // [R17]
                    stab_next = {STAB_W{1'b0}};
                    stab_is_reset_next = i_wake_reset;
                end
            end
            ST_STAB: begin
                // Counted on the oscillator itself, never on the slow enable. [R24]
                if (stab_done) begin
                    state_next = ST_RUN; // [R23]
                end else begin
                    stab_next = stab_reg + 1'b1;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge i_mclk) begin
        if (!i_nrst) begin
            state_reg <= ST_RUN;
            stab_reg <= {STAB_W{1'b0}};
            stab_is_reset_reg <= 1'b0;
            mask_reg <= 1'b1;
            o_cpu_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_timer_clk_en <= 1'b0;
            o_osc_on <= 1'b1;
            o_mask_clear <= 1'b0;
            o_interrupt_mask <= 1'b1;
            o_cc_push <= 1'b0;
            o_irq_service <= 1'b0;
            o_reset_vector_fetch <= 1'b0;
            o_watchdog_reset <= 1'b0;
            o_slow_active <= 1'b0;
            o_mode <= ST_RUN;
        end else begin
            state_reg <= state_next;
            stab_reg <= stab_next;
            stab_is_reset_reg <= stab_is_reset_next;
            mask_reg <= mask_next;
            o_interrupt_mask <= mask_next;
            o_mode <= state_next;
            o_slow_active <= slow_reg;
            o_mask_clear <= (state_reg == ST_RUN) && (is_wfi || is_halt); // [R5] [R13] [R18]
            o_cpu_clk_en <= (state_next == ST_RUN) && tick; // [R4] [R24]
            o_periph_clk_en <= ((state_next == ST_RUN) || (state_next == ST_WAIT)) && tick; // [R3] [R14]
            // The timer keeps the wake-up time base in every state but full halt.
            o_timer_clk_en <= (state_next != ST_HALT); // [R14]
            o_osc_on <= (state_next != ST_HALT); // [R19] [R17]
            o_watchdog_reset <= (state_reg == ST_RUN) && is_halt && !act_halt_en &&
                i_watchdog_enabled && i_watchdog_halt_option; // [R20]
            // A wake by interrupt is serviced once; a wake by reset fetches the vector.
            o_irq_service <= ((state_reg == ST_WAIT) && i_irq_pending && !i_wake_reset) ||
                ((state_reg == ST_ACTHALT) && !i_wake_reset && i_irq_pending &&
                i_irq_timer_wake) ||
                ((state_reg == ST_STAB) && stab_done && !stab_is_reset_reg); // [R6] [R12]
            o_cc_push <= ((state_reg == ST_WAIT) && i_irq_pending && !i_wake_reset) ||
                ((state_reg == ST_ACTHALT) && !i_wake_reset && i_irq_pending &&
                i_irq_timer_wake) ||
                ((state_reg == ST_STAB) && stab_done && !stab_is_reset_reg); // [R7]
            o_reset_vector_fetch <= ((state_reg == ST_WAIT) && i_wake_reset) ||
                ((state_reg == ST_STAB) && stab_done && stab_is_reset_reg); // [R11] [R17]
        end
    end
    // The external reset length is the board's job; this block only sees i_wake_reset. [R21]
endmodule // low_power_mode_controller
`default_nettype wire

/* File: test/low_power_chk.sv */
// Port level assertions for the low power mode controller.
`timescale 1ns/100ps
`default_nettype none
module low_power_chk #(
    parameter STAB_CYCLES = 256
) (
    input wire logic i_mclk, i_nrst, i_instr_valid, i_slow_select_bit,
    input wire logic [7:0] i_opcode,
    input wire logic i_timebase_irq_enable, i_overflow_irq_enable,
    input wire logic i_timer_clock_select_high, i_timer_clock_select_low,
    input wire logic i_watchdog_enabled, i_watchdog_halt_option,
    input wire logic i_irq_pending, i_irq_timer_wake, i_wake_reset,
    input wire logic o_cpu_clk_en, o_periph_clk_en, o_timer_clk_en, o_osc_on,
    input wire logic o_mask_clear, o_watchdog_reset, o_slow_active,
    input wire logic [4:0] o_mode
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    wire timer_halt_ok = i_timebase_irq_enable
        | (i_overflow_irq_enable & !i_timer_clock_select_high & i_timer_clock_select_low);
    wire wdg_trip = i_watchdog_enabled & i_watchdog_halt_option;
    reg [15:0] stab_cnt;
    // Counts cycles spent stabilising so the full count can be checked at exit.
    always @(posedge i_mclk) begin
        stab_cnt <= (!i_nrst || o_mode != 5'h10) ? 16'h0000 : stab_cnt + 16'h0001;
    end
    sequence s_halt;
        i_instr_valid && i_opcode == 8'h8e && o_mode == 5'h01;
    endsequence
    a_full_halt_entry: assert property (s_halt ##0 (!timer_halt_ok && !wdg_trip)
        |-> ##[1:2] o_mode == 5'h08) else $error("full halt not entered");
    a_active_halt_entry: assert property (s_halt ##0 timer_halt_ok
        |-> ##[1:2] o_mode == 5'h04) else $error("active halt not entered");
    a_watchdog_refuse: assert property (s_halt ##0 (!timer_halt_ok && wdg_trip)
        |-> ##[1:2] (o_watchdog_reset && o_mode == 5'h01)) else $error("no watchdog reset");
    a_full_halt_off: assert property (o_mode == 5'h08 |-> !o_osc_on && !o_cpu_clk_en
        && !o_periph_clk_en && !o_timer_clk_en) else $error("clock alive in full halt");
    a_active_clocks: assert property (o_mode == 5'h04 |-> o_osc_on && o_timer_clk_en
        && !o_cpu_clk_en && !o_periph_clk_en) else $error("wrong clocks in active halt");
    a_wait_cpu_stop: assert property (o_mode == 5'h02 |-> !o_cpu_clk_en && o_osc_on)
        else $error("cpu clocked in wait");
    a_entry_mask_clear: assert property ($rose(o_mode == 5'h08)
        || $rose(o_mode == 5'h04) |-> o_mask_clear) else $error("mask not cleared");
    a_stab_count: assert property ($fell(o_mode == 5'h10)
        |-> o_mode == 5'h01 && stab_cnt == STAB_CYCLES) else $error("stabilise length");
    a_active_irq_wake: assert property (o_mode == 5'h04 && i_irq_pending
        && i_irq_timer_wake && !i_wake_reset |-> ##[1:3] o_mode == 5'h01)
        else $error("slow irq wake");
    a_active_rst_wake: assert property (o_mode == 5'h04 && i_wake_reset
        |-> ##[1:3] o_mode == 5'h10) else $error("reset wake without delay");
    a_slow_ratio: assert property (o_slow_active && o_periph_clk_en && i_slow_select_bit
        |=> (!o_periph_clk_en || !o_slow_active) [*8]) else $error("slow tick too close");
endmodule // low_power_chk
bind low_power_mode_controller low_power_chk #(.STAB_CYCLES(STAB_CYCLES)) chk_i (.*);
`default_nettype wire

/* File: test/cpu_stub.sv */
// Stand-in for the CPU core on the far side of the controller.
`timescale 1ns/100ps
`default_nettype none
module cpu_stub (
    input wire logic i_mclk,
    input wire logic i_cc_push,
    output logic o_irq_taken
);
    initial o_irq_taken = 1'b0;
    // The core vectors one cycle after the push; the controller raises the mask on the edge after that.
    always @(posedge i_mclk) begin
        o_irq_taken <= i_cc_push;
    end
endmodule // cpu_stub
`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench for the low power mode controller.
`timescale 1ns/100ps
`default_nettype none
`include "power_mode_map.vh"
module tb;
    logic i_mclk = 0, i_nrst = 0, slow = 0, iv = 0, tbe = 0, ovf = 0, ck1 = 0, ck0 = 0;
    logic wdg = 0, opt = 0, irq = 0, cap = 0, twk = 0, wrst = 0, pop = 0, popm = 0;
    logic fetch_seen = 0, svc_seen = 0, wrs_seen = 0;
    logic [7:0] op = 8'h00;
    logic [8:0] rows [5] = '{9'h088, 9'h028, 9'h0e8, 9'h164, 9'h0a4};
    wire logic cpu, per, tmr, osc, mask, push, svc, rvf, wrs, sla, taken;
    wire logic [4:0] mode;
    int failures = 0, cmp_count = 0, cyc = 0, n, g;
    low_power_mode_controller #(.STAB_CYCLES(8), .STAB_W(9)) uut (.i_mclk(i_mclk),
        .i_nrst(i_nrst), .i_slow_select_bit(slow), .i_instr_valid(iv), .i_opcode(op),
        .i_timebase_irq_enable(tbe), .i_overflow_irq_enable(ovf),
        .i_timer_clock_select_high(ck1), .i_timer_clock_select_low(ck0),
        .i_watchdog_enabled(wdg), .i_watchdog_halt_option(opt), .i_irq_pending(irq),
        .i_irq_halt_capable(cap), .i_irq_timer_wake(twk), .i_wake_reset(wrst),
        .i_irq_taken(taken), .i_cc_pop(pop), .i_cc_pop_mask(popm), .o_cpu_clk_en(cpu),
        .o_periph_clk_en(per), .o_timer_clk_en(tmr), .o_osc_on(osc), .o_mask_clear(),
        .o_interrupt_mask(mask), .o_cc_push(push), .o_irq_service(svc),
        .o_reset_vector_fetch(rvf), .o_watchdog_reset(wrs), .o_slow_active(sla), .o_mode(mode));
    cpu_stub partner (.i_mclk(i_mclk), .i_cc_push(push), .o_irq_taken(taken));
    initial forever #10 i_mclk = ~i_mclk;
    // Pulses are caught here so the bench can look at them after long waits.
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (rvf === 1'b1) fetch_seen <= 1'b1;
        if (svc === 1'b1) svc_seen <= 1'b1;
        if (wrs === 1'b1) wrs_seen <= 1'b1;
        if (cyc == 30000) begin
            failures++;
            complete_run;
        end
    end
    task complete_run;
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task instr(input logic [7:0] code);
        @(negedge i_mclk);
        iv = 1'b1;
        op = code;
        @(negedge i_mclk);
        iv = 1'b0;
    endtask
    task wait_mode(input logic [4:0] m);
        n = 0;
        while (mode !== m && n < 3000) begin
            @(negedge i_mclk);
            n++;
        end
        chk(mode, m);
    endtask
    task gap;
        g = 0;
        while (per !== 1'b1 && g < 100) begin
            @(negedge i_mclk);
            g++;
        end
        g = 1;
        @(negedge i_mclk);
        while (per !== 1'b1 && g < 100) begin
            @(negedge i_mclk);
            g++;
        end
    endtask
    task clr;
        fetch_seen = 1'b0;
        svc_seen = 1'b0;
        wrs_seen = 1'b0;
    endtask
    task irq_wake(input logic t, input logic c);
        clr;
        irq = 1'b1;
        twk = t;
        cap = c;
        wait_mode(5'h01);
        irq = 1'b0;
        twk = 1'b0;
        cap = 1'b0;
        repeat (3) @(negedge i_mclk);
        chk(svc_seen, 1'b1);
        chk(mask, 1'b1);
    endtask
    // The wake reset is held for the full minimum, long after stabilising ends.
    task halt_rst(input logic [4:0] m);
        instr(`HALT_OPCODE);
        wait_mode(m);
        chk(mask, 1'b0);
        wrst = 1'b1;
        repeat (`EXT_RESET_MIN_CYCLES) @(negedge i_mclk);
        wrst = 1'b0;
        wait_mode(5'h01);
        chk(fetch_seen, 1'b1);
    endtask
    initial begin
        repeat (20) @(negedge i_mclk);
        chk(mode, 5'h01);
        chk(mask, 1'b1);
        i_nrst = 1'b1;
        slow = 1'b1;
        gap;
        gap;
        chk(g, `SLOW_DIV);
        chk(sla, 1'b1);
        instr(`WFI_OPCODE);
        wait_mode(5'h02);
        gap;
        chk(g, `SLOW_DIV);
        chk(mask, 1'b0);
        irq_wake(1'b0, 1'b0);
        chk(sla, 1'b1);
        pop = 1'b1;
        @(negedge i_mclk);
        pop = 1'b0;
        @(negedge i_mclk);
        chk(mask, popm);
        repeat (10) @(negedge i_mclk);
        slow = 1'b0;
        repeat (40) @(negedge i_mclk);
        gap;
        chk(g, 1);
        tbe = 1'b1;
        instr(`HALT_OPCODE);
        wait_mode(5'h04);
        irq = 1'b1;
        repeat (5) @(negedge i_mclk);
        chk(mode, 5'h04);
        irq_wake(1'b1, 1'b0);
        chk(n <= 3, 1'b1);
        tbe = 1'b0;
        instr(`HALT_OPCODE);
        wait_mode(5'h08);
        chk({osc, tmr, cpu}, 3'b000);
        irq_wake(1'b0, 1'b1);
        wdg = 1'b1;
        opt = 1'b1;
        clr;
        instr(`HALT_OPCODE);
        repeat (4) @(negedge i_mclk);
        chk({mode, wrs_seen}, 6'h03);
        tbe = 1'b1;
        opt = 1'b0;
        clr;
        instr(`HALT_OPCODE);
        wait_mode(5'h04);
        chk(wrs_seen, 1'b0);
        irq_wake(1'b1, 1'b0);
        wdg = 1'b0;
        for (int i = 0; i < 5; i++) begin
            {tbe, ovf, ck1, ck0} = rows[i][8:5];
            clr;
            halt_rst(rows[i][4:0]);
        end
        complete_run;
    end
endmodule // tb
`default_nettype wire
